/* src/cdfb_consts.vh */
// Operation
// - Driver-state flag shows live bus driver state, 1 enabled, 0 disabled.
// - Driver disabled by host receive-only command or by transmit-dominant fault.
// - Real-time status read leaves driver, receiver and wake-receiver flags unchanged.
// - Receiver-state flag shows live bus receiver state, 1 enabled, 0 disabled.
// - Receiver disabled only by host command such as sleep; flag then reads 0.
// - Wake-receiver-state flag reads 1 while wake receiver enabled, else 0.
// - Wake receiver enabled after power-on; later changed only by host command.
// - Wake-up source flag sets on bus wake, clears on host read; code also waits for the wake condition to drop.
// - Overtemperature flag sets above threshold; clears after drop and host read.
// - Receive-pin-low flag sets on short to ground; clears after recovery and read.
// - Receive-pin-high flag sets on stuck recessive; clears after recovery and read.
// - Transmit-dominant flag sets on pin shorted low; clears after recovery and read.
// - Bus-dominant-clamp flag sets past dominant timeout; clears after recovery and read.
// - Overcurrent flag sets above threshold; clears after current drops and read.
// - Pending-bus-failure flag sets on pre-detection; clears after recovery and read.
// - Confirmed-bus-failure flag sets on full detection; clears after recovery and read.
`ifndef CDFB_CONSTS_VH
`define CDFB_CONSTS_VH

// Register byte offsets
`define CDFB_OFS_CTRL     8'h00
`define CDFB_OFS_RTSTAT   8'h04
`define CDFB_OFS_FLAGS    8'h08
`define CDFB_OFS_IRQ_STAT 8'h0c
`define CDFB_OFS_IRQ_MASK 8'h10

// Control bit positions
`define CDFB_CTRL_DRV_EN  0
`define CDFB_CTRL_RX_EN   1
`define CDFB_CTRL_WAKE_EN 2
`define CDFB_CTRL_RXONLY  3
`define CDFB_CTRL_SLEEP   4
`define CDFB_CTRL_RST     5'h07

// Real-time status bit positions
`define CDFB_RT_DRV       0
`define CDFB_RT_RX        1
`define CDFB_RT_WAKE      2

// Latched flag positions
`define CDFB_FL_WAKE      0
`define CDFB_FL_OTEMP     1
`define CDFB_FL_RXLOW     2
`define CDFB_FL_RXHIGH    3
`define CDFB_FL_TXDOM     4
`define CDFB_FL_CLAMP     5
`define CDFB_FL_OCUR      6
`define CDFB_FL_PEND      7
`define CDFB_FL_CONF      8
`define CDFB_NFLAGS       9
`define CDFB_FLAGS_RST    9'h000

// Dominant timeout, microseconds and clock rate
`define CDFB_DOMINANT_TIMEOUT_US      1000
`define CDFB_CLK_MHZ      250
`define CDFB_DOMINANT_TIMEOUT_CYC     (`CDFB_DOMINANT_TIMEOUT_US * `CDFB_CLK_MHZ)

`endif

/* src/cdfb_flag.v */
`timescale 1ns/1ns
// One latched fault flag: set by condition, cleared by read once condition gone
module cdfb_flag (
   input  wire mclk,      // System clock
   input  wire rst_n,     // Synchronised reset, active low
   input  wire cond,      // Synchronised fault condition
   input  wire rd_clr,    // Host read of the flag register
   input  wire live_gate, // 1: clear needs condition gone
   output reg  flag       // Latched flag
);
   // Set dominates; a read while the condition holds keeps the flag
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flag <= 1'b0;
      end else if (cond) begin
         flag <= 1'b1;
      end else if (rd_clr && (!live_gate || !cond)) begin
         flag <= 1'b0;
      end
   end
endmodule // cdfb_flag

/* src/cdfb_bank.v */
`timescale 1ns/1ns
`include "cdfb_consts.vh"
// CAN status and diagnostic flag bank, AHB-Lite slave
module cdfb_bank #(
   parameter DOMINANT_TIMEOUT_CYC = `CDFB_DOMINANT_TIMEOUT_CYC      // Dominant timeout in clock cycles
) (
   input  wire        mclk,          // 250 MHz clock
   input  wire        rstn,          // Async reset, active low
   input  wire        hsel,          // AHB slave select
   input  wire [31:0] haddr,         // AHB address
   input  wire [1:0]  htrans,        // AHB transfer type
   input  wire        hwrite,        // AHB write
   input  wire [2:0]  hsize,         // AHB size
   input  wire [31:0] hwdata,        // AHB write data
   input  wire        hready,        // AHB bus ready
   output reg  [31:0] hrdata,        // AHB read data
   output reg         hreadyout,     // AHB slave ready
   output reg         hresp,         // AHB response, always OKAY
   input  wire        wake_det,      // Bus wake-up detected
   input  wire        otemp_det,     // Thermal sensor above threshold
   input  wire        rxd_low_det,   // Receive pin shorted to ground
   input  wire        rxd_high_det,  // Receive pin stuck recessive
   input  wire        txd_dom_det,   // Transmit pin shorted low
   input  wire        bus_dom,       // Bus currently dominant
   input  wire        ocur_det,      // Current above threshold
   input  wire        fail_pre_det,  // Bus failure pre-detected
   input  wire        fail_conf_det, // Bus failure identified
   output reg         drv_en,        // Bus driver enabled
   output reg         rx_en,         // Bus receiver enabled
   output reg         wake_rx_en,    // Wake-up receiver enabled
   output reg         irq            // Level interrupt
);
   localparam NF = `CDFB_NFLAGS;

   // Reset release through two flops
   reg rst_s1;
   reg rst_n;
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // Two-flop synchronisers for the fault pins
   wire [NF-1:0] raw_in;
   reg  [NF-1:0] in_s1;
   reg  [NF-1:0] in_s2;
   // Raw bus level rides in the clamp slot; cond swaps in the timed clamp
   assign raw_in = {fail_conf_det, fail_pre_det, ocur_det, bus_dom, txd_dom_det,
                    rxd_high_det, rxd_low_det, otemp_det, wake_det};
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         in_s1 <= `CDFB_FLAGS_RST;
         in_s2 <= `CDFB_FLAGS_RST;
      end else begin
         in_s1 <= raw_in;
         in_s2 <= in_s1;
      end
   end

   // Dominant timeout counter; saturates so the clamp stays while dominant
   reg [31:0] dom_cnt;
   reg        clamp;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dom_cnt <= 32'h0000_0000;
         clamp   <= 1'b0;
      end else if (!in_s2[`CDFB_FL_CLAMP]) begin
         dom_cnt <= 32'h0000_0000;
         clamp   <= 1'b0;
      end else if (dom_cnt >= DOMINANT_TIMEOUT_CYC - 1) begin
         clamp   <= 1'b1;
      end else begin
         dom_cnt <= dom_cnt + 32'h0000_0001;
      end
   end

   wire [NF-1:0] cond;
   assign cond = {in_s2[8:6], clamp, in_s2[4:0]};

   // AHB address phase capture
   reg        ph_valid;
   reg        ph_write;
   reg [7:0]  ph_addr;
   wire       take = hsel && hready && htrans[1];
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr  <= 8'h00;
      end else if (hready) begin
         ph_valid <= take;
         ph_write <= hwrite;
         ph_addr  <= haddr[7:0];
      end
   end

   wire wr_en = ph_valid && ph_write;
   wire rd_en = ph_valid && !ph_write;
   wire rd_flags = rd_en && (ph_addr == `CDFB_OFS_FLAGS);

   // Host control register: wake receiver on by default after power-on
   reg [4:0] ctrl;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `CDFB_CTRL_RST;
      end else if (wr_en && ph_addr == `CDFB_OFS_CTRL) begin
         ctrl <= hwdata[4:0];
      end
   end

   // Latched flags; each clears on a read only once its condition is gone, wake flag included
   wire [NF-1:0] flags;
   genvar gi;
   generate
      for (gi = 0; gi < NF; gi = gi + 1) begin : g_flag
         cdfb_flag u_flag (
            .mclk      (mclk),
            .rst_n     (rst_n),
            .cond      (cond[gi]),
            .rd_clr    (rd_flags),
            .live_gate (gi != `CDFB_FL_WAKE),
            .flag      (flags[gi])
         );
      end
   endgenerate

   // Live enable states; reading them has no side effect
   wire next_drv  = ctrl[`CDFB_CTRL_DRV_EN] && !ctrl[`CDFB_CTRL_RXONLY]
                    && !ctrl[`CDFB_CTRL_SLEEP] && !in_s2[`CDFB_FL_TXDOM];
   wire next_rx   = ctrl[`CDFB_CTRL_RX_EN] && !ctrl[`CDFB_CTRL_SLEEP];
   wire next_wake = ctrl[`CDFB_CTRL_WAKE_EN];
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         drv_en     <= 1'b0;
         rx_en      <= 1'b0;
         wake_rx_en <= 1'b1;
      end else begin
         drv_en     <= next_drv;
         rx_en      <= next_rx;
         wake_rx_en <= next_wake;
      end
   end

   // Interrupt status, set wins over write-one clear
   reg [NF-1:0] irq_stat;
   reg [NF-1:0] irq_mask;
   reg [NF-1:0] flags_d;
   wire [NF-1:0] rise = flags & ~flags_d;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat <= `CDFB_FLAGS_RST;
         irq_mask <= `CDFB_FLAGS_RST;
         flags_d  <= `CDFB_FLAGS_RST;
         irq      <= 1'b0;
      end else begin
         flags_d <= flags;
         if (wr_en && ph_addr == `CDFB_OFS_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~hwdata[NF-1:0]) | rise;
         end else begin
            irq_stat <= irq_stat | rise;
         end
         if (wr_en && ph_addr == `CDFB_OFS_IRQ_MASK) begin
            irq_mask <= hwdata[NF-1:0];
         end
         irq <= |(irq_stat & irq_mask);
      end
   end

   // Read mux, unmapped reads zero; answer with zero wait states
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (take && !hwrite) begin
            case (haddr[7:0])
               `CDFB_OFS_CTRL:     hrdata <= {27'h0, ctrl};
               `CDFB_OFS_RTSTAT:   hrdata <= {29'h0, next_wake, next_rx, next_drv};
               `CDFB_OFS_FLAGS:    hrdata <= {23'h0, flags};
               `CDFB_OFS_IRQ_STAT: hrdata <= {23'h0, irq_stat};
               `CDFB_OFS_IRQ_MASK: hrdata <= {23'h0, irq_mask};
               default:            hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // cdfb_bank

/* bench/cdfb_host.sv */
`timescale 1ns/1ns
// Host side: AHB-Lite master, single word transfers only
module cdfb_host (
   input  wire        mclk,   // Clock
   output reg  [31:0] haddr,  // Address
   output reg  [1:0]  htrans, // Transfer type
   output reg         hwrite, // Write
   output reg  [31:0] hwdata, // Write data
   input  wire        hready, // Bus ready
   input  wire [31:0] hrdata  // Read data
);
   initial begin
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
   end
   // Receiver and wake-receiver enables change only through these commands
   task xfer(input [31:0] a, input w, input [31:0] d, output [31:0] q);
      begin
         haddr <= a;
         htrans <= 2'h2;
         hwrite <= w;
         @(posedge mclk);
         while (hready !== 1'b1) @(posedge mclk);
         // Released address shows garbage, not the last value
         htrans <= 2'h0;
         haddr <= ~a;
         hwdata <= w ? d : ~d;
         @(posedge mclk);
         while (hready !== 1'b1) @(posedge mclk);
         q = hrdata;
         hwdata <= ~d;
      end
   endtask
endmodule // cdfb_host

/* bench/cdfb_bank_checker.sv */
`timescale 1ns/1ns
`include "cdfb_consts.vh"
// Port checker; data phases tracked in helper flops
module cdfb_bank_checker (
   input wire        mclk,        // Clock
   input wire        rstn,        // Reset, active low
   input wire        hsel,        // Select
   input wire [31:0] haddr,       // Address
   input wire [1:0]  htrans,      // Transfer type
   input wire        hwrite,      // Write
   input wire [31:0] hwdata,      // Write data
   input wire        hready,      // Bus ready
   input wire [31:0] hrdata,      // Read data
   input wire        txd_dom_det, // Transmit pin fault
   input wire        ocur_det,    // Overcurrent
   input wire        drv_en,      // Driver on
   input wire        rx_en,       // Receiver on
   input wire        wake_rx_en   // Wake receiver on
);
   reg  ph_ctrl;
   reg  ph_rt;
   reg  ph_fl;
   wire take = hsel & hready & htrans[1];
   // Marks the data phase of control writes and of status and flag reads
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ph_ctrl <= 1'b0;
         ph_rt <= 1'b0;
         ph_fl <= 1'b0;
      end else if (hready) begin
         ph_ctrl <= take & hwrite & (haddr[7:0] == `CDFB_OFS_CTRL);
         ph_rt <= take & !hwrite & (haddr[7:0] == `CDFB_OFS_RTSTAT);
         ph_fl <= take & !hwrite & (haddr[7:0] == `CDFB_OFS_FLAGS);
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   txdom_drv_a: assert property (txd_dom_det[*4] |-> !drv_en)
      else $error("driver on with transmit fault");
   rxonly_drv_a: assert property (ph_ctrl && hwdata[3] |-> ##[1:2] !drv_en)
      else $error("driver on in receive-only");
   sleep_off_a: assert property (ph_ctrl && hwdata[4] |-> ##[1:2] !rx_en && !drv_en)
      else $error("receiver on in sleep");
   wake_off_a: assert property (ph_ctrl && !hwdata[2] |-> ##[1:2] !wake_rx_en)
      else $error("wake receiver not off");
   enable_on_a: assert property ((!txd_dom_det)[*4] ##0 ph_ctrl && hwdata[4:0] == 5'h07
      |-> ##[1:2] drv_en && rx_en)
      else $error("driver or receiver not on");
   rt_read_a: assert property ($stable({wake_rx_en, rx_en, drv_en})[*3] ##0 ph_rt
      |-> hrdata[2:0] == {wake_rx_en, rx_en, drv_en})
      else $error("live status read wrong");
   flag_hold_a: assert property (ocur_det[*6] ##1 ph_fl |-> hrdata[6])
      else $error("overcurrent flag lost");
   txdom_flag_a: assert property (txd_dom_det[*6] ##1 ph_fl |-> hrdata[4])
      else $error("transmit flag missing");
   wake_cmd_a: assert property ($changed(wake_rx_en) |-> $past(ph_ctrl) || $past(ph_ctrl, 2))
      else $error("wake receiver changed without command");
endmodule // cdfb_bank_checker
bind cdfb_bank cdfb_bank_checker chk_i (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .txd_dom_det(txd_dom_det), .ocur_det(ocur_det), .drv_en(drv_en), .rx_en(rx_en),
   .wake_rx_en(wake_rx_en));

/* bench/cdfb_bank_tb.sv */
`timescale 1ns/1ns
`include "cdfb_consts.vh"
// Bank bench: host model on the bus, fault conditions driven here
module cdfb_bank_tb;
   localparam [31:0] A_CT = {24'h0, `CDFB_OFS_CTRL};
   localparam [31:0] A_RT = {24'h0, `CDFB_OFS_RTSTAT};
   localparam [31:0] A_FL = {24'h0, `CDFB_OFS_FLAGS};
   localparam [31:0] A_IS = {24'h0, `CDFB_OFS_IRQ_STAT};
   localparam [31:0] A_MS = {24'h0, `CDFB_OFS_IRQ_MASK};
   reg         mclk;
   reg         rstn;
   reg  [8:0]  cnd;
   reg  [31:0] b;
   reg  [31:0] q;
   wire [31:0] haddr;
   wire [31:0] hwdata;
   wire [31:0] hrdata;
   wire [1:0]  htrans;
   wire        hwrite;
   wire        hrdy;
   wire        hresp;
   wire        drv_en;
   wire        rx_en;
   wire        wake_rx_en;
   wire        irq;
   integer     err_total;
   integer     n_checks;
   integer     i;
   integer     cyc = 0;
   cdfb_host host (.mclk(mclk), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata));
   // Short timeout so the clamp count stays quick
   cdfb_bank #(.DOMINANT_TIMEOUT_CYC(8)) uut (.mclk(mclk), .rstn(rstn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
      .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .wake_det(cnd[0]), .otemp_det(cnd[1]),
      .rxd_low_det(cnd[2]), .rxd_high_det(cnd[3]), .txd_dom_det(cnd[4]), .bus_dom(cnd[5]),
      .ocur_det(cnd[6]), .fail_pre_det(cnd[7]), .fail_conf_det(cnd[8]), .drv_en(drv_en),
      .rx_en(rx_en), .wake_rx_en(wake_rx_en), .irq(irq));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task results;
      begin
         if (err_total == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            err_total = err_total + 1;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   task rd(input [31:0] a, input [31:0] e);
      begin
         host.xfer(a, 1'b0, 32'h0, q);
         chk(q, e);
         chk({31'h0, hresp}, 32'h0);
      end
   endtask
   task wr(input [31:0] a, input [31:0] d);
      host.xfer(a, 1'b1, d, q);
   endtask
   // Hang guard, well above the few hundred cycles needed
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         err_total = err_total + 1;
         results;
      end
   end
   initial begin
      rstn = 1'b0;
      cnd = 9'h000;
      err_total = 0;
      n_checks = 0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(A_RT, 32'h7);
      rd(A_RT, 32'h7);
      wr(A_CT, 32'h06);
      rd(A_RT, 32'h6);
      wr(A_CT, 32'h05);
      rd(A_RT, 32'h5);
      wr(A_CT, 32'h0f);
      rd(A_RT, 32'h6);
      wr(A_CT, 32'h17);
      rd(A_RT, 32'h4);
      wr(A_CT, 32'h03);
      rd(A_RT, 32'h3);
      // Mid-run reset must bring the wake receiver back on
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(A_RT, 32'h7);
      wr(A_CT, 32'h07);
      wr(32'h40, 32'hffffffff);
      rd(32'h40, 32'h0);
      // Dominant shorter than the timeout leaves no clamp
      cnd[5] <= 1'b1;
      repeat (4) @(posedge mclk);
      cnd[5] <= 1'b0;
      repeat (4) @(posedge mclk);
      rd(A_FL, 32'h0);
      wr(A_MS, 32'h1fe);
      rd(A_MS, 32'h1fe);
      // Each flag: set, read while present (wake flag only after it drops), recover, read twice
      for (i = 0; i < 9; i = i + 1) begin
         b = 32'h1 << i;
         cnd[i] <= 1'b1;
         repeat (14) @(posedge mclk);
         if (i == 0) cnd[0] <= 1'b0;
         repeat (4) @(posedge mclk);
         chk({31'h0, irq}, {31'h0, (i > 0)});
         rd(A_FL, b);
         rd(A_FL, i ? b : 32'h0);
         if (i == 4) rd(A_RT, 32'h6);
         cnd[i] <= 1'b0;
         repeat (4) @(posedge mclk);
         rd(A_FL, i ? b : 32'h0);
         rd(A_FL, 32'h0);
         wr(A_IS, b);
         rd(A_IS, 32'h0);
         chk({31'h0, irq}, 32'h0);
      end
      rd(A_RT, 32'h7);
      results;
   end
endmodule // cdfb_bank_tb
